// [hdl/pm_regs_pkg.sv]
// Package for the power-management event register set.
// Assumes a single core clock and a byte-wide special-function-register bus.
package pm_regs_pkg;
  localparam logic [7:0] ADDR_WRITE_KEY = 8'hC1;
  localparam logic [7:0] ADDR_ADC_START = 8'hD8;
  localparam logic [7:0] ADDR_EVENT_ENABLE = 8'hEC;
  localparam logic [7:0] ADDR_PERIPHERAL_CONFIG_STATUS_CFG = 8'hF4;
  localparam logic [7:0] ADDR_SWITCHOVER = 8'hF5;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'hF8;
  localparam logic [7:0] ADDR_INT_PIN_CFG = 8'hFF;
  localparam logic [7:0] UNLOCK_KEY = 8'hEA;
  // Flag and enable bit positions
  localparam int BIT_SUPPLY_RESTORED = 7;
  localparam int BIT_SUMMARY = 6;
  localparam int BIT_SAG = 5;
  localparam int BIT_RESERVED4 = 4;
  localparam int BIT_DCIN_CONV = 3;
  localparam int BIT_BATTERY = 2;
  localparam int BIT_SWITCHOVER = 1;
  localparam int BIT_DCIN_LOW = 0;
  // Event bits that feed the summary flag
  localparam logic [7:0] EVENT_MASK = 8'hAF;
  // Peripheral configuration fields
  localparam int BIT_RX_WAKE = 7;
  localparam int BIT_SUPPLY_SOURCE = 6;
  localparam int BIT_MAIN_GOOD = 5;
  localparam int BIT_PLL_FAULT = 4;
  localparam int BIT_SLEEP_REF = 3;
  localparam int BIT_PLL_ACK = 0;
  localparam logic [7:0] PERIPHERAL_CONFIG_STATUS_WRITE_MASK = 8'h0B;
  localparam logic [7:0] SWITCHOVER_WRITE_MASK = 8'h03;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_INT_PIN_CFG = 8'h00;
  localparam logic [1:0] RX_GPIO = 2'h0;
  localparam logic [1:0] RX_SERIAL = 2'h1;
  localparam logic [1:0] RX_SERIAL_WAKE = 2'h3;
  localparam logic [1:0] SWO_LOW_MAIN = 2'h0;
  localparam logic [1:0] SWO_LOW_MAIN_DCIN = 2'h1;
endpackage

// [hdl/in_sync.sv]
// Two-flop synchroniser bank for asynchronous status and event inputs.
// Assumes inputs arrive from outside the core clock domain.
module in_sync
  import pm_regs_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk, // core clock
  input wire logic reset, // synchronous reset
  input wire logic [WIDTH-1:0] async_in, // raw inputs
  output logic [WIDTH-1:0] sync_out // synchronised levels
);
  logic [WIDTH-1:0] stage1;

  // First stage is read only by the second
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// [hdl/edge_detect.sv]
// Rising-edge pulse generator, one per bit.
// Assumes inputs are already in the core clock domain.
module edge_detect #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk, // core clock
  input wire logic reset, // synchronous reset
  input wire logic [WIDTH-1:0] level_in, // synchronised levels
  output logic [WIDTH-1:0] rise_pulse // one-cycle rise pulses
);
  logic [WIDTH-1:0] level_prev;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      level_prev <= '0;
    end else begin
      level_prev <= level_in;
    end
  end

  // Edge per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_edge
      assign rise_pulse[i] = level_in[i] & ~level_prev[i];
    end
  endgenerate
endmodule

// [hdl/power_mgmt_event_regs.sv]
// Power-management event flags, enables, policy and status registers.
// Assumes a byte-wide register bus on the core clock; event inputs are asynchronous.
module power_mgmt_event_regs
  import pm_regs_pkg::*;
(
  input wire logic ref_clk, // core clock, 50 MHz
  input wire logic reset, // synchronous, active high
  input wire logic [7:0] sfr_addr, // register address
  input wire logic [7:0] sfr_wdata, // write data
  input wire logic sfr_wr, // write strobe, one cycle
  input wire logic sfr_rd, // read strobe, one cycle
  output logic [7:0] sfr_rdata, // read data, valid cycle after strobe
  input wire logic main_supply_select, // 1 while internal supply is main
  input wire logic main_supply_good, // main supply ready
  input wire logic sag_event, // sag condition from metering
  input wire logic dcin_change_event, // DC-in changed by threshold
  input wire logic dcin_ready_event, // DC-in measurement ready
  input wire logic battery_low_event, // battery below threshold
  input wire logic battery_ready_event, // battery measurement ready
  input wire logic dcin_low, // DC-in below 1.2 V
  input wire logic pll_lock_lost, // PLL lost lock
  input wire logic rx_wake_event, // receive edge woke deep sleep
  output logic power_event_irq, // power-saving-mode interrupt request
  output logic switchover_on_main_low, // policy: switch on low main
  output logic switchover_on_dcin_low, // policy: switch on low DC-in
  output logic sleep_reference_enable, // keep reference on in deep sleep
  output logic [1:0] receive_pin_function, // receive pin mode
  output logic rx_wake_enable, // edge wake-up armed
  output logic [7:0] interrupt_pin_config // protected config value
);
  // Register map: key C1, ADC start D8 (write only here), enable EC,
  // peripheral F4, switchover F5, flags F8, interrupt pin config FF
  // Writes take effect on the strobe edge; read data is registered on that same edge

  // Sync lane map, lowest first
  // 0 main supply select, inverted
  // 1 main supply good, inverted
  // 2 sag report
  // 3 DC-in change
  // 4 DC-in measurement ready
  // 5 battery low
  // 6 battery measurement ready
  // 7 DC-in low
  // 8 PLL loss of lock
  // 9 receive wake edge
  // Two flops plus the edge stage put a flag three edges after its input rises
  // Inputs must be high at one edge at least or the event may be missed
  localparam int NSYNC = 10;

  // Synchroniser and edge-detector lanes
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_lv;
  logic [NSYNC-1:0] rise;
  // Software-visible register state
  logic [7:0] write_key_register;
  logic [7:0] power_event_flags;
  logic [7:0] power_event_enable;
  logic [7:0] switchover_policy;
  logic [7:0] peripheral_config_status_ctrl;
  // Sticky status and supply history
  logic receive_wake_flag;
  logic pll_fault;
  logic supply_prev;

  // Inputs in sync order; the supply-select level is edge-tracked separately
  // Supply levels enter inverted so the cleared synchroniser reads main and good
  // Without that, release from reset would fake a switchover and a restore
  assign raw_in = {rx_wake_event, pll_lock_lost, dcin_low, battery_ready_event,
                   battery_low_event, dcin_ready_event, dcin_change_event,
                   sag_event, ~main_supply_good, ~main_supply_select};

  // Two flops on every asynchronous input
  in_sync #(.WIDTH(NSYNC)) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(raw_in),
    .sync_out(sync_lv)
  );

  // One-cycle rise pulses from the synchronised levels
  edge_detect #(.WIDTH(NSYNC)) u_edge (
    .ref_clk(ref_clk),
    .reset(reset),
    .level_in(sync_lv),
    .rise_pulse(rise)
  );

  // Supply status back in true polarity; both read 1 straight out of reset
  wire supply_is_main = ~sync_lv[0];
  wire supply_good = ~sync_lv[1];

  // Address decode
  // Unmapped addresses decode to nothing, so writes there are dropped
  wire wr_key = sfr_wr && (sfr_addr == ADDR_WRITE_KEY);
  wire wr_adc = sfr_wr && (sfr_addr == ADDR_ADC_START);
  wire wr_enable = sfr_wr && (sfr_addr == ADDR_EVENT_ENABLE);
  wire wr_peripheral_config_status = sfr_wr && (sfr_addr == ADDR_PERIPHERAL_CONFIG_STATUS_CFG);
  wire wr_policy = sfr_wr && (sfr_addr == ADDR_SWITCHOVER);
  wire wr_flags = sfr_wr && (sfr_addr == ADDR_EVENT_FLAGS);
  // Key is judged in the very cycle of the protected write
  wire unlocked = (write_key_register == UNLOCK_KEY);
  wire wr_intpin = sfr_wr && (sfr_addr == ADDR_INT_PIN_CFG) && unlocked;

  // Supply-source transitions, taken after synchronisation
  // A one-cycle pulse each way; the level itself lives in supply_prev
  wire to_main = supply_is_main & ~supply_prev;
  wire to_battery = ~supply_is_main & supply_prev;

  // Named rise pulses, one per event source
  wire sag_rise = rise[2]; // sag report
  wire dcin_change_rise = rise[3]; // DC-in moved by its threshold
  wire dcin_ready_rise = rise[4]; // DC-in measurement ready
  wire battery_low_rise = rise[5]; // battery below threshold
  wire battery_ready_rise = rise[6]; // battery measurement ready
  wire dcin_low_rise = rise[7]; // DC-in fell below 1.2 V
  wire pll_loss_rise = rise[8]; // PLL lost lock
  wire rx_wake_rise = rise[9]; // receive edge woke deep sleep

  // Event set vector, one bit per flag position
  // Summary and reserved positions are never set from here
  wire [7:0] event_set;
  assign event_set[BIT_SUPPLY_RESTORED] = to_main;
  assign event_set[BIT_SUMMARY] = 1'b0;
  assign event_set[BIT_SAG] = sag_rise;
  assign event_set[BIT_RESERVED4] = 1'b0;
  assign event_set[BIT_DCIN_CONV] = dcin_change_rise | dcin_ready_rise;
  assign event_set[BIT_BATTERY] = battery_low_rise | battery_ready_rise;
  assign event_set[BIT_SWITCHOVER] = to_battery;
  assign event_set[BIT_DCIN_LOW] = dcin_low_rise;

  // Enabled event occurring now sets the summary flag
  // A late enable on an old flag does not set it; only a fresh edge counts
  wire summary_set = |(event_set & power_event_enable & EVENT_MASK);

  // Software write-zero clear; unwritten bits keep their value
  // Writing one keeps a flag, so software can clear bits singly
  wire [7:0] flag_clear = wr_flags ? ~sfr_wdata : RESET_ZERO;
  wire [7:0] set_vec = event_set | {1'b0, summary_set, 6'h00};
  // Set wins over a clear in the same cycle
  wire [7:0] next_flags = (power_event_flags & ~flag_clear) | set_vec;

  // Interrupt level: any flag with matching enable
  // Summary bit stays out of the gate; it only reports
  wire next_irq = |(next_flags & power_event_enable & EVENT_MASK);

  // PLL acknowledge on the ADC start register clears the fault
  // Only the acknowledge bit of that register is used here
  wire pll_ack = wr_adc && sfr_wdata[BIT_PLL_ACK];
  // A new loss of lock in the acknowledge cycle keeps the fault up
  wire next_pll_fault = pll_loss_rise | (pll_fault & ~pll_ack);
  // Receive-wake flag clears on a zero written to its bit; a new edge wins
  wire rx_clear = wr_peripheral_config_status & ~sfr_wdata[BIT_RX_WAKE];
  wire next_rx_flag = rx_wake_rise | (receive_wake_flag & ~rx_clear);

  // Peripheral register read view
  wire [7:0] peripheral_config_status_view = {receive_wake_flag, supply_is_main, supply_good, pll_fault,
                            peripheral_config_status_ctrl[3:0]};

  // Read mux; unmapped addresses read zero
  // Key reads back so software can see whether the lock is open
  logic [7:0] read_mux;
  always_comb begin
    case (sfr_addr)
      ADDR_WRITE_KEY: read_mux = write_key_register;
      ADDR_EVENT_ENABLE: read_mux = power_event_enable;
      ADDR_PERIPHERAL_CONFIG_STATUS_CFG: read_mux = peripheral_config_status_view;
      ADDR_SWITCHOVER: read_mux = switchover_policy;
      ADDR_EVENT_FLAGS: read_mux = power_event_flags;
      ADDR_INT_PIN_CFG: read_mux = interrupt_pin_config;
      default: read_mux = RESET_ZERO;
    endcase
  end

  // Key register: software relocks by writing zero
  // Any value other than the key keeps the pin config shut
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      write_key_register <= RESET_ZERO;
    end else if (wr_key) begin
      write_key_register <= sfr_wdata;
    end
  end

  // Protected pin configuration
  // Only the key-gated strobe loads it, guarding against runaway code
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      interrupt_pin_config <= RESET_INT_PIN_CFG;
    end else if (wr_intpin) begin
      interrupt_pin_config <= sfr_wdata;
    end
  end

  // Enable register; reserved bits 6 and 4 never store
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      power_event_enable <= RESET_ZERO;
    end else if (wr_enable) begin
      power_event_enable <= sfr_wdata & EVENT_MASK;
    end
  end

  // Switchover policy; only the two-bit select stores
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      switchover_policy <= RESET_ZERO;
    end else if (wr_policy) begin
      switchover_policy <= sfr_wdata & SWITCHOVER_WRITE_MASK;
    end
  end

  // Peripheral control bits; status bits come from live logic instead
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      peripheral_config_status_ctrl <= RESET_ZERO;
    end else if (wr_peripheral_config_status) begin
      peripheral_config_status_ctrl <= sfr_wdata & PERIPHERAL_CONFIG_STATUS_WRITE_MASK;
    end
  end

  // Latched event flags; reserved bit 4 forced low
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      power_event_flags <= RESET_ZERO;
    end else begin
      power_event_flags <= next_flags & ~(8'h01 << BIT_RESERVED4);
    end
  end

  // PLL fault holds until the acknowledge bit is written
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pll_fault <= 1'b0;
    end else begin
      pll_fault <= next_pll_fault;
    end
  end

  // Receive-wake flag
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      receive_wake_flag <= 1'b0;
    end else begin
      receive_wake_flag <= next_rx_flag;
    end
  end

  // Last supply source; reset to main so release makes no edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      supply_prev <= 1'b1;
    end else begin
      supply_prev <= supply_is_main;
    end
  end

  // Interrupt output registered from the next flag state
  // Built from next flags so the request rises with the flag itself
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      power_event_irq <= 1'b0;
    end else begin
      power_event_irq <= next_irq;
    end
  end

  // Switch on low main supply unless the upper select bit disables it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      switchover_on_main_low <= 1'b1;
    end else begin
      switchover_on_main_low <= ~switchover_policy[1];
    end
  end

  // DC-in switchover only for select 01
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      switchover_on_dcin_low <= 1'b0;
    end else begin
      switchover_on_dcin_low <= (switchover_policy[1:0] == SWO_LOW_MAIN_DCIN);
    end
  end

  // Reference kept on in deep sleep; software sets it when the display stays on
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sleep_reference_enable <= 1'b0;
    end else begin
      sleep_reference_enable <= peripheral_config_status_ctrl[BIT_SLEEP_REF];
    end
  end

  // Receive pin mode straight from the control field
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      receive_pin_function <= RX_GPIO;
    end else begin
      receive_pin_function <= peripheral_config_status_ctrl[1:0];
    end
  end

  // Wake-up armed only for the serial-with-wake code
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_wake_enable <= 1'b0;
    end else begin
      rx_wake_enable <= (peripheral_config_status_ctrl[1:0] == RX_SERIAL_WAKE);
    end
  end

  // Read data registered one cycle after the strobe
  // Holds between strobes, so a late look still sees the last read
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sfr_rdata <= RESET_ZERO;
    end else if (sfr_rd) begin
      sfr_rdata <= read_mux;
    end
  end
endmodule

// [test/pm_regs_chk.sv]
// Port-level checker for the power-management event register set.
// Assumes it is bound to the top module and sees its ports only.
module pm_regs_chk
  import pm_regs_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic reset, // sync reset
  input wire logic [7:0] sfr_addr, // address
  input wire logic [7:0] sfr_wdata, // write data
  input wire logic sfr_wr, // write strobe
  input wire logic sfr_rd, // read strobe
  input wire logic [7:0] sfr_rdata, // read data
  input wire logic power_event_irq, // interrupt
  input wire logic switchover_on_main_low, // policy
  input wire logic switchover_on_dcin_low, // policy
  input wire logic [1:0] receive_pin_function, // pin mode
  input wire logic rx_wake_enable, // wake armed
  input wire logic [7:0] interrupt_pin_config // protected value
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [7:0] key_q;
  // Decodes; D8 counts as mapped, so its read value is not checked
  wire pin_wr = sfr_wr && sfr_addr == ADDR_INT_PIN_CFG;
  wire mapped = sfr_addr inside {8'hC1, 8'hD8, 8'hEC, 8'hF4, 8'hF5, 8'hF8, 8'hFF};
  // Shadow of the key so the lock can be judged from the ports
  always_ff @(posedge ref_clk) begin
    if (reset) key_q <= 8'h00;
    else if (sfr_wr && sfr_addr == ADDR_WRITE_KEY) key_q <= sfr_wdata;
  end
  // Register-path checks
  a_pin_cfg_locked: assert property (pin_wr && key_q != UNLOCK_KEY |=> $stable(interrupt_pin_config))
    else $error("pin config changed while locked");
  a_pin_cfg_write: assert property (pin_wr && key_q == UNLOCK_KEY |=> interrupt_pin_config == $past(sfr_wdata))
    else $error("unlocked pin config write lost");
  a_pin_cfg_cause: assert property ($changed(interrupt_pin_config) && !$past(reset) |-> $past(pin_wr))
    else $error("pin config changed without a write");
  a_reset_defaults: assert property ($fell(reset) |-> switchover_on_main_low && !switchover_on_dcin_low && interrupt_pin_config == RESET_INT_PIN_CFG)
    else $error("wrong values after reset");
  a_policy_pair: assert property (switchover_on_dcin_low |-> switchover_on_main_low)
    else $error("policy decode impossible pair");
  a_wake_decode: assert property (rx_wake_enable == (receive_pin_function == RX_SERIAL_WAKE))
    else $error("wake arm does not match pin mode");
  a_irq_masked: assert property (sfr_wr && sfr_addr == ADDR_EVENT_ENABLE && sfr_wdata == 8'h00 |-> ##2 !power_event_irq [*3])
    else $error("irq with all enables clear");
  a_unmapped_zero: assert property (sfr_rd && !mapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  c_unlock: cover property (pin_wr && key_q == UNLOCK_KEY);
  c_irq: cover property ($rose(power_event_irq));
  c_wake: cover property (rx_wake_enable);
endmodule
bind power_mgmt_event_regs pm_regs_chk chk_u (.ref_clk, .reset, .sfr_addr, .sfr_wdata, .sfr_wr,
  .sfr_rd, .sfr_rdata, .power_event_irq, .switchover_on_main_low, .switchover_on_dcin_low,
  .receive_pin_function, .rx_wake_enable, .interrupt_pin_config);

// [test/tb.sv]
// Self-checking bench for the power-management event register set.
// Assumes the checker is bound in; event inputs are held several cycles.
module tb;
  import pm_regs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 0, reset = 1, sfr_wr = 0, sfr_rd = 0, msel = 1, mgood = 1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, pin_cfg, ev = 8'h00;
  logic irq, sw_main, sw_dcin, sref, wake;
  logic [1:0] rpf;
  int bad_count = 0, samples_checked = 0, cycles = 0;
  // Flag expected from each of the first six event inputs
  localparam logic [7:0] FLAG_OF [6] = '{8'h20, 8'h08, 8'h08, 8'h04, 8'h04, 8'h01};
  power_mgmt_event_regs dut_u (.ref_clk(ref_clk), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .main_supply_select(msel), .main_supply_good(mgood), .sag_event(ev[0]),
    .dcin_change_event(ev[1]), .dcin_ready_event(ev[2]), .battery_low_event(ev[3]),
    .battery_ready_event(ev[4]), .dcin_low(ev[5]), .pll_lock_lost(ev[6]),
    .rx_wake_event(ev[7]), .power_event_irq(irq), .switchover_on_main_low(sw_main),
    .switchover_on_dcin_low(sw_dcin), .sleep_reference_enable(sref),
    .receive_pin_function(rpf), .rx_wake_enable(wake), .interrupt_pin_config(pin_cfg));
  // Clock, 20 ns period
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // Hang guard, well above the run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask
  // Read data lands on the edge after the strobe edge
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    @(negedge ref_clk);
    chk(what, sfr_rdata, exp);
  endtask
  // Held long enough to clear the two-flop synchroniser
  task automatic pulse(input int b);
    @(posedge ref_clk);
    ev[b] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    ev[b] <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic t_defaults();
    rchk("enable", ADDR_EVENT_ENABLE, 8'h00);
    rchk("flags", ADDR_EVENT_FLAGS, 8'h00);
    rchk("peripheral_config_status", ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'h60);
    rchk("unmapped", 8'h10, 8'h00);
    chk("main_low", {7'h00, sw_main}, 8'h01);
    $display("defaults done");
  endtask
  task automatic t_key();
    wr(ADDR_INT_PIN_CFG, 8'h80);
    rchk("locked", ADDR_INT_PIN_CFG, 8'h00);
    wr(ADDR_WRITE_KEY, UNLOCK_KEY);
    wr(ADDR_INT_PIN_CFG, 8'h80);
    rchk("unlocked", ADDR_INT_PIN_CFG, 8'h80);
    wr(ADDR_WRITE_KEY, 8'h00);
    wr(ADDR_INT_PIN_CFG, 8'h11);
    @(negedge ref_clk);
    chk("relocked", pin_cfg, 8'h80);
    $display("key done");
  endtask
  task automatic t_events();
    wr(ADDR_EVENT_ENABLE, EVENT_MASK);
    for (int i = 0; i < 6; i++) begin
      pulse(i);
      rchk("event", ADDR_EVENT_FLAGS, FLAG_OF[i] | 8'h40);
      chk("irq", {7'h00, irq}, 8'h01);
      wr(ADDR_EVENT_FLAGS, 8'h00);
      rchk("cleared", ADDR_EVENT_FLAGS, 8'h00);
      chk("irq off", {7'h00, irq}, 8'h00);
    end
    @(posedge ref_clk);
    msel <= 1'b0;
    mgood <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rchk("to battery", ADDR_EVENT_FLAGS, 8'h42);
    rchk("on battery", ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'h00);
    wr(ADDR_EVENT_FLAGS, 8'h00);
    msel <= 1'b1;
    mgood <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rchk("restored", ADDR_EVENT_FLAGS, 8'hC0);
    $display("events done");
  endtask
  task automatic t_mask();
    wr(ADDR_EVENT_ENABLE, 8'h00);
    wr(ADDR_EVENT_FLAGS, 8'h00);
    pulse(0);
    rchk("masked", ADDR_EVENT_FLAGS, 8'h20);
    chk("irq masked", {7'h00, irq}, 8'h00);
    wr(ADDR_EVENT_ENABLE, 8'h20);
    rchk("late enable", ADDR_EVENT_ENABLE, 8'h20);
    chk("irq late", {7'h00, irq}, 8'h01);
    wr(ADDR_EVENT_ENABLE, 8'h00);
    wr(ADDR_EVENT_FLAGS, 8'h00);
    $display("mask done");
  endtask
  task automatic t_peripheral_config_status();
    pulse(6);
    rchk("pll lost", ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'h70);
    wr(ADDR_ADC_START, 8'h01);
    rchk("pll ack", ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'h60);
    pulse(7);
    rchk("rx wake", ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'hE0);
    wr(ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'h0B);
    rchk("peripheral_config_status wr", ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'h6B);
    chk("pin mode", {4'h0, sref, 1'b0, rpf}, 8'h0B);
    chk("wake on", {7'h00, wake}, 8'h01);
    wr(ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'h01);
    rchk("serial", ADDR_PERIPHERAL_CONFIG_STATUS_CFG, 8'h61);
    chk("wake off", {6'h00, wake, sref}, 8'h00);
    $display("peripheral_config_status done");
  endtask
  task automatic t_policy();
    for (int v = 0; v < 4; v++) begin
      wr(ADDR_SWITCHOVER, 8'(v));
      rchk("policy", ADDR_SWITCHOVER, 8'(v));
      chk("decode", {6'h00, sw_main, sw_dcin}, v == 0 ? 8'h02 : v == 1 ? 8'h03 : 8'h00);
    end
    $display("policy done");
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    t_defaults();
    t_key();
    t_events();
    t_mask();
    t_peripheral_config_status();
    t_policy();
    close_out();
  end
endmodule
